/* logic/afgb_pkg.sv */
// Shared widths and reset values for the FIFO glue bridge
package afgb_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Data widths
    localparam int HOST_W = 32;
    localparam int LANE_W = 16;
    localparam int FIFO_W = 18;
    localparam int PAD_W  = FIFO_W - LANE_W;

    // Lane positions on the host bus
    localparam int LANE_LO_LSB = 0;
    localparam int LANE_HI_LSB = 16;

    // Number of FIFOs ganged side by side
    localparam int NUM_FIFO = 2;

    ////////////////////////////////////////////////////////////////////////////
    // Fill value of the unused FIFO write bits
    localparam logic [PAD_W-1:0] PAD_FILL = 2'h0;

    // Reset values of the registered status outputs
    localparam logic EMPTY_RST = 1'h1;
    localparam logic FULL_RST  = 1'h0;

    // Idle level of every active-low FIFO control
    localparam logic CTRL_IDLE = 1'h1;

endpackage : afgb_pkg

/* logic/afgb_lane_pack.sv */
// Width expansion: two narrow FIFO lanes form one host word
`timescale 1ns/1ns

module afgb_lane_pack (
    // Host side
    input  logic [afgb_pkg::HOST_W-1:0] host_wdata,
    output logic [afgb_pkg::HOST_W-1:0] host_rdata,
    // FIFO side
    input  logic [afgb_pkg::FIFO_W-1:0] rdata_lo,
    input  logic [afgb_pkg::FIFO_W-1:0] rdata_hi,
    output logic [afgb_pkg::FIFO_W-1:0] wdata_lo,
    output logic [afgb_pkg::FIFO_W-1:0] wdata_hi
);

    ////////////////////////////////////////////////////////////////////////////
    // Top two bits of each FIFO are not wired to the host
    always_comb begin
        wdata_lo   = {afgb_pkg::PAD_FILL,
                      host_wdata[afgb_pkg::LANE_LO_LSB +: afgb_pkg::LANE_W]};
        wdata_hi   = {afgb_pkg::PAD_FILL,
                      host_wdata[afgb_pkg::LANE_HI_LSB +: afgb_pkg::LANE_W]};
        host_rdata = {rdata_hi[afgb_pkg::LANE_W-1:0],
                      rdata_lo[afgb_pkg::LANE_W-1:0]};
    end

endmodule : afgb_lane_pack

/* logic/afgb_bridge.sv */
// Glue between an asynchronous host memory port and asynchronous or strobed FIFOs
//
// Behaviour
// - Low 16 bits of two 18-bit FIFOs form one 32-bit host path.
// - Read enable is select OR read strobe; write enable select OR write strobe.
// - Strobed FIFO write cycle matches the asynchronous FIFO write cycle.
// - Unload, load and output enable are select ORed with matching strobe.
`timescale 1ns/1ns

module afgb_bridge (
    // Clock and reset, used only by the status flags
    input  logic                        sys_clk,
    input  logic                        nrst,
    // Configuration strap: high selects strobed FIFOs
    input  logic                        strobed_mode,
    // Host memory port strobes
    input  logic                        chip_select_n,
    input  logic                        async_read_strobe_n,
    input  logic                        async_write_strobe_n,
    input  logic                        async_output_enable_n,
    // Host data bus, split into in, out and enable
    input  logic [afgb_pkg::HOST_W-1:0] host_data_in,
    output logic [afgb_pkg::HOST_W-1:0] host_data_out,
    output logic                        host_data_oe,
    // Asynchronous FIFO controls
    output logic                        fifo_read_enable_n,
    output logic                        fifo_write_enable_n,
    // Strobed FIFO controls
    output logic                        unload_strobe,
    output logic                        load_strobe,
    output logic                        fifo_output_enable_n,
    // FIFO data lanes
    input  logic [afgb_pkg::FIFO_W-1:0] fifo_rdata_lo,
    input  logic [afgb_pkg::FIFO_W-1:0] fifo_rdata_hi,
    output logic [afgb_pkg::FIFO_W-1:0] fifo_wdata_lo,
    output logic [afgb_pkg::FIFO_W-1:0] fifo_wdata_hi,
    // FIFO flags, one bit per FIFO
    input  logic [afgb_pkg::NUM_FIFO-1:0] empty_flag_n,
    input  logic [afgb_pkg::NUM_FIFO-1:0] full_flag_n,
    // Combined status for the host
    output logic                        fifo_empty,
    output logic                        fifo_full
);

    ////////////////////////////////////////////////////////////////////////////
    // Width expansion
    logic [afgb_pkg::HOST_W-1:0] packed_rdata;

    afgb_lane_pack u_lane_pack (
        .host_wdata (host_data_in),
        .host_rdata (packed_rdata),
        .rdata_lo   (fifo_rdata_lo),
        .rdata_hi   (fifo_rdata_hi),
        .wdata_lo   (fifo_wdata_lo),
        .wdata_hi   (fifo_wdata_hi)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Control glue
    // Kept clockless on purpose: any register here would delay the FIFO
    // strobes behind the host strobes and break the host's capture edge.
    logic rd_gate_n;
    logic wr_gate_n;
    logic oe_gate_n;

    always_comb begin
        rd_gate_n = chip_select_n | async_read_strobe_n;
        wr_gate_n = chip_select_n | async_write_strobe_n;
        oe_gate_n = chip_select_n | async_output_enable_n;
        // Unused style idles high so a wrong FIFO type never sees a strobe
        if (strobed_mode) begin
            fifo_read_enable_n   = afgb_pkg::CTRL_IDLE;
            fifo_write_enable_n  = afgb_pkg::CTRL_IDLE;
            unload_strobe        = rd_gate_n;
            load_strobe          = wr_gate_n;
            fifo_output_enable_n = oe_gate_n;
        end else begin
            fifo_read_enable_n   = rd_gate_n;
            fifo_write_enable_n  = wr_gate_n;
            unload_strobe        = afgb_pkg::CTRL_IDLE;
            load_strobe          = afgb_pkg::CTRL_IDLE;
            fifo_output_enable_n = afgb_pkg::CTRL_IDLE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Host read data return
    // The host bus is driven only while the FIFOs drive toward the host,
    // so a write into this space never fights the host's own drivers.
    always_comb begin
        host_data_out = packed_rdata;
        if (strobed_mode) begin
            host_data_oe = ~oe_gate_n;
        end else begin
            host_data_oe = ~rd_gate_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Combined flag status
    // Flags are unclocked at the FIFO; one register stage here means a
    // reader must allow a cycle after a strobe before trusting the status.
    logic next_fifo_empty;
    logic next_fifo_full;

    always_comb begin
        next_fifo_empty = ~(&empty_flag_n);
        next_fifo_full  = ~(&full_flag_n);
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            fifo_empty <= afgb_pkg::EMPTY_RST;
            fifo_full  <= afgb_pkg::FULL_RST;
        end else begin
            fifo_empty <= next_fifo_empty;
            fifo_full  <= next_fifo_full;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    property p_lane_read;
        @(posedge sys_clk) disable iff (!nrst)
        host_data_oe |-> (host_data_out[15:0] == fifo_rdata_lo[15:0]) &&
                         (host_data_out[31:16] == fifo_rdata_hi[15:0]);
    endproperty
    a_lane_read: assert property (p_lane_read)
        else $error("Read lanes not joined into host word");

    property p_lane_write;
        @(posedge sys_clk) disable iff (!nrst)
        (fifo_wdata_lo == {2'h0, host_data_in[15:0]}) &&
        (fifo_wdata_hi == {2'h0, host_data_in[31:16]});
    endproperty
    a_lane_write: assert property (p_lane_write)
        else $error("Write lanes not split from host word");

    property p_async_read;
        @(posedge sys_clk) disable iff (!nrst)
        !strobed_mode |-> (fifo_read_enable_n == (chip_select_n | async_read_strobe_n));
    endproperty
    a_async_read: assert property (p_async_read)
        else $error("Async read enable not select OR read strobe");

    property p_async_write;
        @(posedge sys_clk) disable iff (!nrst)
        (!strobed_mode && chip_select_n) |-> fifo_write_enable_n && load_strobe;
    endproperty
    a_async_write: assert property (p_async_write)
        else $error("Write enable active without chip select");

    property p_unload;
        @(posedge sys_clk) disable iff (!nrst)
        strobed_mode |-> (unload_strobe == (chip_select_n | async_read_strobe_n)) &&
                         fifo_read_enable_n;
    endproperty
    a_unload: assert property (p_unload)
        else $error("Unload strobe wrong in strobed mode");

    property p_out_en;
        @(posedge sys_clk) disable iff (!nrst)
        strobed_mode |-> (fifo_output_enable_n == (chip_select_n | async_output_enable_n))
                         && (host_data_oe == !fifo_output_enable_n);
    endproperty
    a_out_en: assert property (p_out_en)
        else $error("Output enable not select OR output strobe");

    property p_same_write;
        @(posedge sys_clk) disable iff (!nrst)
        (load_strobe & fifo_write_enable_n) == (chip_select_n | async_write_strobe_n);
    endproperty
    a_same_write: assert property (p_same_write)
        else $error("Strobed write differs from async write");

    property p_no_delay;
        @(posedge sys_clk) disable iff (!nrst)
        (!strobed_mode && !chip_select_n && $fell(async_read_strobe_n))
            |-> !fifo_read_enable_n && host_data_oe;
    endproperty
    a_no_delay: assert property (p_no_delay)
        else $error("Read enable lags the host read strobe");

    property p_async_idle;
        @(posedge sys_clk) disable iff (!nrst)
        !strobed_mode |-> (host_data_oe == !fifo_read_enable_n) && unload_strobe &&
                          fifo_output_enable_n;
    endproperty
    a_async_idle: assert property (p_async_idle)
        else $error("Async mode leaves strobed pins active or host enable wrong");

    property p_load;
        @(posedge sys_clk) disable iff (!nrst)
        strobed_mode |-> (load_strobe == (chip_select_n | async_write_strobe_n)) &&
                         fifo_write_enable_n;
    endproperty
    a_load: assert property (p_load)
        else $error("Load strobe not select OR write strobe");

    property p_write_no_delay;
        @(posedge sys_clk) disable iff (!nrst)
        (!chip_select_n && $fell(async_write_strobe_n))
            |-> !(load_strobe & fifo_write_enable_n);
    endproperty
    a_write_no_delay: assert property (p_write_no_delay)
        else $error("Write strobe to FIFO lags the host write strobe");

    property p_status;
        @(posedge sys_clk) disable iff (!nrst)
        ##1 (fifo_empty == !(&$past(empty_flag_n))) &&
            (fifo_full == !(&$past(full_flag_n)));
    endproperty
    a_status: assert property (p_status)
        else $error("Combined status does not follow flags");

endmodule : afgb_bridge

/* testbench/afgb_fifo_model.sv */
// Behavioural model of one 18-bit asynchronous or strobed FIFO
`timescale 1ns/1ns

module afgb_fifo_model #(
    parameter int DEPTH = 4
) (
    // Mode strap and FIFO controls
    input  wire logic        strobed_mode,
    input  wire logic        fifo_read_enable_n,
    input  wire logic        fifo_write_enable_n,
    input  wire logic        unload_strobe,
    input  wire logic        load_strobe,
    input  wire logic        fifo_output_enable_n,
    // Data and flags
    input  wire logic [17:0] wdata,
    output wire logic [17:0] rdata,
    output wire logic        empty_flag_n,
    output wire logic        full_flag_n
);
    logic [17:0] mem[$];
    logic [17:0] head = 18'h0;
    int          count = 0;
    wire         drive = strobed_mode ? !fifo_output_enable_n : !fifo_read_enable_n;

    // Released bus shows the inverse, so a stale word can never pass as fresh
    assign rdata        = drive ? head : ~head;
    assign empty_flag_n = (count != 0);
    assign full_flag_n  = (count < DEPTH);

    task automatic push();
        if (count < DEPTH) begin
            mem.push_back(wdata);
            count = mem.size();
            head  = mem[0];
        end
    endtask : push

    task automatic pop();
        if (count != 0) begin
            void'(mem.pop_front());
            count = mem.size();
            if (count != 0) head = mem[0];
        end
    endtask : pop

    // Time-zero guard: outputs settling from unknown are not strobe edges
    always @(posedge fifo_write_enable_n) if (!strobed_mode && $time > 0) push();
    always @(posedge load_strobe) if (strobed_mode && $time > 0) push();
    always @(posedge fifo_read_enable_n) if (!strobed_mode && $time > 0) pop();
    always @(posedge unload_strobe) if (strobed_mode && $time > 0) pop();
endmodule : afgb_fifo_model

/* testbench/test_afgb_bridge.sv */
// Self-checking bench for the FIFO glue bridge with two FIFO models
`timescale 1ns/1ns

module test_afgb_bridge;
    localparam int DEPTH = 4;
    logic sys_clk = 1'h0, nrst = 1'h0, strobed_mode = 1'h0;
    logic chip_select_n = 1'h1, async_read_strobe_n = 1'h1;
    logic async_write_strobe_n = 1'h1, async_output_enable_n = 1'h1;
    logic [31:0] host_data_in = 32'h0, host_data_out;
    logic host_data_oe, fifo_read_enable_n, fifo_write_enable_n, unload_strobe, load_strobe;
    logic fifo_output_enable_n, fifo_empty, fifo_full;
    logic [17:0] fifo_rdata_lo, fifo_rdata_hi, fifo_wdata_lo, fifo_wdata_hi;
    logic [1:0]  empty_flag_n, full_flag_n;
    int          fails = 0, samples_checked = 0, seed = 23;
    logic [31:0] q[$];
    logic r, w, o, prev_r = 1'h1, prev_w = 1'h1, exp_empty = 1'h1, exp_full = 1'h0;

    afgb_bridge u_afgb_bridge (.sys_clk, .nrst, .strobed_mode, .chip_select_n,
        .async_read_strobe_n, .async_write_strobe_n, .async_output_enable_n, .host_data_in,
        .host_data_out, .host_data_oe, .fifo_read_enable_n, .fifo_write_enable_n,
        .unload_strobe, .load_strobe, .fifo_output_enable_n, .fifo_rdata_lo, .fifo_rdata_hi,
        .fifo_wdata_lo, .fifo_wdata_hi, .empty_flag_n, .full_flag_n, .fifo_empty, .fifo_full);

    afgb_fifo_model #(.DEPTH(DEPTH)) u_afgb_fifo_model_lo (.strobed_mode, .fifo_read_enable_n,
        .fifo_write_enable_n, .unload_strobe, .load_strobe, .fifo_output_enable_n,
        .wdata(fifo_wdata_lo), .rdata(fifo_rdata_lo), .empty_flag_n(empty_flag_n[0]),
        .full_flag_n(full_flag_n[0]));
    afgb_fifo_model #(.DEPTH(DEPTH)) u_afgb_fifo_model_hi (.strobed_mode, .fifo_read_enable_n,
        .fifo_write_enable_n, .unload_strobe, .load_strobe, .fifo_output_enable_n,
        .wdata(fifo_wdata_hi), .rdata(fifo_rdata_hi), .empty_flag_n(empty_flag_n[1]),
        .full_flag_n(full_flag_n[1]));

    initial forever #4 sys_clk = ~sys_clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic results();
        $display("Checks %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : results

    ////////////////////////////////////////////////////////////////////////////
    // Reference model, sampled mid-cycle where every glue output has settled
    always @(negedge sys_clk) if (nrst) begin
        r = chip_select_n | async_read_strobe_n;
        w = chip_select_n | async_write_strobe_n;
        o = chip_select_n | async_output_enable_n;
        check(fifo_read_enable_n, strobed_mode ? 1'h1 : r);
        check(fifo_write_enable_n, strobed_mode ? 1'h1 : w);
        check(unload_strobe, strobed_mode ? r : 1'h1);
        check(load_strobe, strobed_mode ? w : 1'h1);
        check(fifo_output_enable_n, strobed_mode ? o : 1'h1);
        check(fifo_wdata_lo, {2'h0, host_data_in[15:0]});
        check(fifo_wdata_hi, {2'h0, host_data_in[31:16]});
        check(host_data_oe, !(strobed_mode ? o : r));
        check(fifo_empty, exp_empty);
        check(fifo_full, exp_full);
        if (!(strobed_mode ? o : r) && q.size() != 0) check(host_data_out, q[0]);
        if (r && !prev_r && q.size() != 0) void'(q.pop_front());
        if (w && !prev_w && q.size() < DEPTH) q.push_back(host_data_in);
        prev_r    = r;
        prev_w    = w;
        exp_empty = (q.size() == 0);
        exp_full  = (q.size() == DEPTH);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Random traffic; write data only changes while no write is in progress
    task automatic run(input logic mode, input int bias, input int n);
        int   op;
        logic rdv;
        @(posedge sys_clk);
        {chip_select_n, async_read_strobe_n, async_write_strobe_n, async_output_enable_n} <= 4'hf;
        @(posedge sys_clk);
        strobed_mode <= mode;
        repeat (n) begin
            @(posedge sys_clk);
            op  = $unsigned($random(seed)) % 8;
            rdv = (op < bias) || (op == 6);
            if (chip_select_n | async_write_strobe_n) host_data_in <= $random(seed);
            chip_select_n         <= (op == 7);
            async_write_strobe_n  <= !(op < bias);
            async_read_strobe_n   <= rdv;
            async_output_enable_n <= mode ? rdv : 1'($random(seed));
        end
    endtask : run

    initial begin
        repeat (4) @(posedge sys_clk);
        nrst <= 1'h1;
        run(1'h0, 6, 200);
        run(1'h0, 1, 200);
        run(1'h1, 6, 200);
        run(1'h1, 1, 200);
        results();
    end

    // About three times the expected run length
    initial begin
        #20000;
        fails++;
        results();
    end
endmodule : test_afgb_bridge
